/* hw/power_sel_pkg.sv */
// Shared constants and types for the power selector and status flags
package power_sel_pkg;

    // Status word layout
    localparam int unsigned          FLAGS_WIDTH     = 16;
    localparam int unsigned          FLAG_BAT_CONN   = 6;
    localparam int unsigned          FLAG_ADP_CONN   = 7;
    localparam int unsigned          FLAG_THERM_SHDN = 8;
    localparam int unsigned          FLAG_TS_COLD    = 9;
    localparam int unsigned          FLAG_TS_HOT     = 10;
    localparam logic [15:0]          FLAGS_RESET     = 16'h0000;

    // Control word: calibration (learn) mode select bit
    localparam int unsigned          CTRL_WIDTH      = 16;
    localparam int unsigned          CTRL_LEARN_BIT  = 4;

    // Junction temperature trip points, degrees C (comparators are analog)
    localparam int unsigned          TJ_TRIP_C       = 145;
    localparam int unsigned          TJ_RESTART_C    = 130;

    // Thermal supervisor states
    typedef enum logic {
        TH_RUN,
        TH_SHUTDOWN
    } thermal_state_t;

endpackage

/* hw/thermal_if.sv */
// Signals between the selector core and the thermal supervisor
interface thermal_if;
    logic junction_above_trip;   // Comparator: above trip point
    logic junction_below_rest;   // Comparator: below restart point
    logic shutdown;              // Charger held off
    logic alarm;                 // One-cycle alarm on entry

    modport supervisor (
        input  junction_above_trip,
        input  junction_below_rest,
        output shutdown,
        output alarm
    );

    modport core (
        output junction_above_trip,
        output junction_below_rest,
        input  shutdown,
        input  alarm
    );
endinterface

/* hw/thermal_supervisor.sv */
// Junction over-temperature shutdown with hysteresis and auto restart
module thermal_supervisor
    import power_sel_pkg::*;
(
    // Clock and reset
    input  wire logic     i_clk,
    input  wire logic     i_rst_b,
    // Thermal signals
    thermal_if.supervisor th
);

    thermal_state_t state;
    thermal_state_t next_state;
    logic           alarm;

    // Trip enters shutdown; only the lower restart point leaves it
    always_comb
    begin
        next_state = state;
        case (state)
            TH_RUN:
                if (th.junction_above_trip)
                    next_state = TH_SHUTDOWN;
            TH_SHUTDOWN:
                if (th.junction_below_rest)
                    next_state = TH_RUN;
            default:
                next_state = TH_RUN;
        endcase
    end

    // State and alarm pulse
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_b)
        begin
            state <= TH_RUN;
            alarm <= 1'b0;
        end
        else
        begin
            state <= next_state;
            alarm <= (state == TH_RUN) && (next_state == TH_SHUTDOWN);
        end
    end

    assign th.shutdown = (state == TH_SHUTDOWN);
    assign th.alarm    = alarm;

    // Trip in run state forces shutdown and alarm next cycle
    trip_shutdown_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        (!th.shutdown && th.junction_above_trip) |=> (th.shutdown && alarm))
        else $error("over-temperature trip did not shut down");

    // Shutdown holds until restart comparator reports cool
    hold_shutdown_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        (th.shutdown && !th.junction_below_rest) |=> th.shutdown)
        else $error("charger restarted before cooling");

endmodule

/* hw/power_selector_status.sv */
// System power selector, protection and condition flag word
import power_sel_pkg::*;

//
// Operation
// - Flag bit 6 follows the battery switch drive.
// - Battery switch on with no adapter, or adapter plus learn mode.
// - Learn mode and depleted battery hands the rail to the adapter.
// - Rail above battery by 150 mV keeps the battery switch off.
// - Flag bit 7 follows the adapter switch drive.
// - Adapter switch on only with adapter present and learn mode clear or the depleted handover made.
// - Adapter overcurrent drops the adapter switch at the next clock edge.
// - Flag bit 8 shows the charger held off for over-temperature.
// - Junction above 145 C disables the charger and raises an alarm.
// - The host link keeps working during thermal shutdown.
// - Charger restarts by itself once junction is below 130 C.
// - Flag bit 9 shows the thermistor above the cold threshold.
// - Flag bit 10 shows the thermistor below the hot threshold.
// - Hot threshold differs before and during charging.
// - Five-volt reference (and thermistor flags) only with adapter.
module power_selector_status
    import power_sel_pkg::*;
#(
    parameter int unsigned FLAGS_W = FLAGS_WIDTH
)
(
    // Clock and reset
    input  wire logic                  I_CORE_CLK,
    input  wire logic                  I_RST_B,
    // Host control word
    input  wire logic [CTRL_WIDTH-1:0] I_CONTROL_WORD,
    // Selector comparators
    input  wire logic                  I_ADAPTER_PRESENCE_INPUT,
    input  wire logic                  I_BATTERY_BELOW_DEPLETED,
    input  wire logic                  I_SYSTEM_RAIL_ABOVE_BATTERY,
    input  wire logic                  I_ADAPTER_OVERCURRENT,
    // Junction temperature comparators
    input  wire logic                  I_JUNCTION_ABOVE_TRIP,
    input  wire logic                  I_JUNCTION_BELOW_RESTART,
    // Thermistor comparators and charge state
    input  wire logic                  I_THERMISTOR_ABOVE_COLD,
    input  wire logic                  I_THERMISTOR_BELOW_HOT_START,
    input  wire logic                  I_THERMISTOR_BELOW_HOT_RUN,
    input  wire logic                  I_CHARGING,
    // Switch drives and enables
    output logic                       O_BATTERY_SWITCH_DRIVE,
    output logic                       O_ADAPTER_SWITCH_DRIVE,
    output logic                       O_CHARGER_ENABLE,
    output logic                       O_FIVE_VOLT_REFERENCE_EN,
    output logic                       O_HOT_THRESHOLD_RUN_SEL,
    // Host status
    output logic                       O_THERMAL_ALARM,
    output logic [FLAGS_W-1:0]         O_CONDITION_FLAGS
);

    // Flag word must hold every documented bit
    if (FLAGS_W < FLAG_TS_HOT + 1)
    begin : g_width_check
        $error("FLAGS_W too small for condition flags");
    end

    thermal_if th ();

    logic               learn_mode;
    logic               depleted_handover;
    logic               next_handover;
    logic               next_bat_drive;
    logic               next_adp_drive;
    logic               ts_hot_selected;
    logic [FLAGS_W-1:0] next_flags;

    // Thermal supervisor runs beside the selector; host link untouched
    thermal_supervisor u_thermal (
        .i_clk   (I_CORE_CLK),
        .i_rst_b (I_RST_B),
        .th      (th.supervisor)
    );

    assign th.junction_above_trip = I_JUNCTION_ABOVE_TRIP;
    assign th.junction_below_rest = I_JUNCTION_BELOW_RESTART;

    // Learn mode comes straight from the control word
    assign learn_mode = I_CONTROL_WORD[CTRL_LEARN_BIT];

    // Handover latches so a recovering battery does not bounce back
    assign next_handover = learn_mode && I_ADAPTER_PRESENCE_INPUT
                           && (depleted_handover
                               || I_BATTERY_BELOW_DEPLETED);

    // Battery switch selection, with surge guard overriding all modes
    assign next_bat_drive = (!I_ADAPTER_PRESENCE_INPUT
                             || (learn_mode && !next_handover))
                            && !I_SYSTEM_RAIL_ABOVE_BATTERY;

    // Adapter switch selection, overcurrent wins over everything
    assign next_adp_drive = I_ADAPTER_PRESENCE_INPUT
                            && (!learn_mode || next_handover)
                            && !I_ADAPTER_OVERCURRENT;

    // Hot comparator chosen by charge state
    assign ts_hot_selected = I_CHARGING ? I_THERMISTOR_BELOW_HOT_RUN
                                        : I_THERMISTOR_BELOW_HOT_START;

    // Live condition word; thermistor flags gated off while reference is down
    always_comb
    begin
        next_flags                  = FLAGS_W'(FLAGS_RESET);
        next_flags[FLAG_BAT_CONN]   = next_bat_drive;
        next_flags[FLAG_ADP_CONN]   = next_adp_drive;
        next_flags[FLAG_THERM_SHDN] = th.shutdown;
        next_flags[FLAG_TS_COLD]    = I_ADAPTER_PRESENCE_INPUT
                                      && I_THERMISTOR_ABOVE_COLD;
        next_flags[FLAG_TS_HOT]     = I_ADAPTER_PRESENCE_INPUT
                                      && ts_hot_selected;
    end

    // Drives and flags update together so the word never disagrees
    always_ff @(posedge I_CORE_CLK)
    begin
        if (!I_RST_B)
        begin
            depleted_handover      <= 1'b0;
            O_BATTERY_SWITCH_DRIVE <= 1'b0;
            O_ADAPTER_SWITCH_DRIVE <= 1'b0;
            O_CONDITION_FLAGS      <= FLAGS_W'(FLAGS_RESET);
        end
        else
        begin
            depleted_handover      <= next_handover;
            O_BATTERY_SWITCH_DRIVE <= next_bat_drive;
            O_ADAPTER_SWITCH_DRIVE <= next_adp_drive;
            O_CONDITION_FLAGS      <= next_flags;
        end
    end

    // Enables and alarm; no host read path feeds back here
    always_ff @(posedge I_CORE_CLK)
    begin
        if (!I_RST_B)
        begin
            O_CHARGER_ENABLE         <= 1'b0;
            O_FIVE_VOLT_REFERENCE_EN <= 1'b0;
            O_HOT_THRESHOLD_RUN_SEL  <= 1'b0;
            O_THERMAL_ALARM          <= 1'b0;
        end
        else
        begin
            O_CHARGER_ENABLE         <= !th.shutdown;
            O_FIVE_VOLT_REFERENCE_EN <= I_ADAPTER_PRESENCE_INPUT;
            O_HOT_THRESHOLD_RUN_SEL  <= I_CHARGING;
            O_THERMAL_ALARM          <= th.alarm;
        end
    end

    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (!I_RST_B);

    // Bit 6 and the battery drive always agree
    bat_flag_a: assert property (
        O_CONDITION_FLAGS[FLAG_BAT_CONN] == O_BATTERY_SWITCH_DRIVE)
        else $error("battery flag differs from drive");

    // Bit 7 and the adapter drive always agree
    adp_flag_a: assert property (
        O_CONDITION_FLAGS[FLAG_ADP_CONN] == O_ADAPTER_SWITCH_DRIVE)
        else $error("adapter flag differs from drive");

    // No adapter and no surge gives battery on next cycle
    bat_select_a: assert property (
        (!I_ADAPTER_PRESENCE_INPUT && !I_SYSTEM_RAIL_ABOVE_BATTERY)
        |=> O_BATTERY_SWITCH_DRIVE)
        else $error("battery not selected without adapter");

    // Surge guard
    surge_guard_a: assert property (
        I_SYSTEM_RAIL_ABOVE_BATTERY |=> !O_BATTERY_SWITCH_DRIVE)
        else $error("battery switch on during surge");

    // Presence, learn mode clear and no overcurrent give the adapter switch
    adp_select_a: assert property (
        (I_ADAPTER_PRESENCE_INPUT && !learn_mode && !I_ADAPTER_OVERCURRENT)
        |=> O_ADAPTER_SWITCH_DRIVE)
        else $error("adapter not selected");

    // Overcurrent drops the adapter switch
    overcurrent_off_a: assert property (
        I_ADAPTER_OVERCURRENT |=> !O_ADAPTER_SWITCH_DRIVE)
        else $error("adapter switch on during overcurrent");

    // Depleted battery during learn hands over in one cycle
    sequence s_learn_depleted;
        learn_mode && I_ADAPTER_PRESENCE_INPUT && I_BATTERY_BELOW_DEPLETED
        && !I_ADAPTER_OVERCURRENT;
    endsequence
    depleted_handover_a: assert property (
        s_learn_depleted |=> (O_ADAPTER_SWITCH_DRIVE
                              && !O_BATTERY_SWITCH_DRIVE))
        else $error("no handover on depleted battery");

    // Shutdown flag held two cycles; charger disabled by the second
    sequence s_shutdown_seen;
        O_CONDITION_FLAGS[FLAG_THERM_SHDN] ##1
        O_CONDITION_FLAGS[FLAG_THERM_SHDN];
    endsequence
    therm_disable_a: assert property (
        s_shutdown_seen |-> !O_CHARGER_ENABLE)
        else $error("charger enabled during thermal shutdown");

    // Flag word keeps tracking the selector while the charger is held off
    flags_live_a: assert property (
        (th.shutdown && !I_ADAPTER_PRESENCE_INPUT
         && !I_SYSTEM_RAIL_ABOVE_BATTERY)
        |=> O_CONDITION_FLAGS[FLAG_BAT_CONN])
        else $error("flag word frozen during thermal shutdown");

    // Thermistor flags dead without the reference
    ts_gate_a: assert property (
        !I_ADAPTER_PRESENCE_INPUT |=> (O_CONDITION_FLAGS[FLAG_TS_COLD] == 1'b0
                                       && !O_CONDITION_FLAGS[FLAG_TS_HOT]))
        else $error("thermistor flag without reference");

    // Hot flag uses running threshold while charging
    ts_hot_run_a: assert property (
        (I_ADAPTER_PRESENCE_INPUT && I_CHARGING)
        |=> (O_CONDITION_FLAGS[FLAG_TS_HOT]
             == $past(I_THERMISTOR_BELOW_HOT_RUN)))
        else $error("wrong hot threshold while charging");

endmodule

/* sim/analog_front_model.sv */
// Analog front end model: sensed levels to comparator outputs
module analog_front_model
(
    // Sensed levels from the bench
    input  wire logic [15:0] i_temp_c,
    input  wire logic [15:0] i_sys_mv,
    input  wire logic [15:0] i_bat_mv,
    input  wire logic        i_learn,
    input  wire logic [15:0] i_ctrl_rest,
    // Comparator outputs and host control word
    output logic             o_above_trip,
    output logic             o_below_restart,
    output logic             o_rail_above,
    output logic [15:0]      o_control_word
);
    timeunit 1ns;
    timeprecision 1ps;

    // Junction comparators, hysteresis band between them
    assign o_above_trip    = i_temp_c > 16'd145;
    assign o_below_restart = i_temp_c < 16'd130;
    // Surge comparator; a rail exactly 150 mV up is not a surge
    assign o_rail_above    = i_sys_mv > i_bat_mv + 16'd150;
    // Host owns the other control bits; noise there must not matter
    assign o_control_word  = {i_ctrl_rest[15:5], i_learn,
                              i_ctrl_rest[3:0]};
endmodule

/* sim/power_selector_status_test.sv */
// Randomised self-checking bench for the power selector and flags
module power_selector_status_test
    import power_sel_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk, rst_b, adp, dep, oc, cold, hs, hr, chg, learn;
    logic        trip, rest, surge, hold;
    logic        bat_d, adp_d, en, ref_en, hsel, alarm;
    logic [15:0] ctl, ctrl_rest, temp, sys_mv, bat_mv, flags;
    logic [2:0]  sh;
    logic [22:0] q[$];
    int          err_total, checked, cyc;

    // 50 MHz core clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    power_selector_status power_selector_status_i (
        .I_CORE_CLK(clk), .I_RST_B(rst_b), .I_CONTROL_WORD(ctl),
        .I_ADAPTER_PRESENCE_INPUT(adp), .I_BATTERY_BELOW_DEPLETED(dep),
        .I_SYSTEM_RAIL_ABOVE_BATTERY(surge), .I_ADAPTER_OVERCURRENT(oc),
        .I_JUNCTION_ABOVE_TRIP(trip), .I_JUNCTION_BELOW_RESTART(rest),
        .I_THERMISTOR_ABOVE_COLD(cold), .I_THERMISTOR_BELOW_HOT_START(hs),
        .I_THERMISTOR_BELOW_HOT_RUN(hr), .I_CHARGING(chg),
        .O_BATTERY_SWITCH_DRIVE(bat_d), .O_ADAPTER_SWITCH_DRIVE(adp_d),
        .O_CHARGER_ENABLE(en), .O_FIVE_VOLT_REFERENCE_EN(ref_en),
        .O_HOT_THRESHOLD_RUN_SEL(hsel), .O_THERMAL_ALARM(alarm),
        .O_CONDITION_FLAGS(flags));

    analog_front_model analog_front_model_i (
        .i_temp_c(temp), .i_sys_mv(sys_mv), .i_bat_mv(bat_mv),
        .i_learn(learn), .i_ctrl_rest(ctrl_rest), .o_above_trip(trip),
        .o_below_restart(rest), .o_rail_above(surge), .o_control_word(ctl));

    // Compare one observed value with its note
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Drive one random cycle and note what the next edge must give
    task automatic step(input logic r);
        logic        hand, c, bd, ad, sx;
        logic [15:0] f;
        @(posedge clk);
        #1;
        rst_b = r;
        adp = ($urandom_range(0, 4) != 0);
        learn = 1'($urandom_range(0, 1));
        dep = ($urandom_range(0, 3) == 0);
        oc = ($urandom_range(0, 7) == 0);
        {cold, hs, hr, chg} = 4'($urandom);
        ctrl_rest = 16'($urandom);
        bat_mv = 16'd10000 + 16'($urandom_range(0, 4000));
        sys_mv = bat_mv + 16'($urandom_range(0, 300)) - 16'd100;
        temp = temp + 16'($urandom_range(0, 6)) - 16'd3;
        if (temp < 16'd110 || temp > 16'd160)
            temp = 16'd140;
        sx = sys_mv > bat_mv + 16'd150;
        // Handover sticks while learn and adapter both stay
        hand = r & learn & adp & (hold | dep);
        c = r & ((temp > 16'd145) | (sh[0] & ~(temp < 16'd130)));
        hold = hand;
        sh = {sh[1:0], c};
        bd = ~sx & (~adp | (learn & ~hand));
        ad = adp & ~oc & (~learn | hand);
        f = 16'h0000;
        f[FLAG_BAT_CONN] = bd;
        f[FLAG_ADP_CONN] = ad;
        f[FLAG_THERM_SHDN] = sh[1];
        f[FLAG_TS_COLD] = adp & cold;
        f[FLAG_TS_HOT] = adp & (chg ? hr : hs);
        // Enable and alarm register the same shutdown state as flag 8;
        // a reset cycle must leave every output at zero
        q.push_back(r ? {1'b1, bd, ad, ~sh[1], adp, chg, sh[1] & ~sh[2], f}
                      : 23'h400000);
    endtask

    // Monitor: settled outputs against the oldest note
    initial
    begin
        logic [22:0] n;
        forever
        begin
            @(posedge clk);
            #2;
            if (q.size() > 1)
            begin
                n = q.pop_front();
                if (n[22])
                begin
                    check(bat_d, n[21]);
                    check(adp_d, n[20]);
                    check(en, n[19]);
                    check(ref_en, n[18]);
                    check(hsel, n[17]);
                    check(alarm, n[16]);
                    check(flags, n[15:0]);
                end
            end
        end
    end

    // Hang guard, well above the planned cycle count
    always @(posedge clk)
    begin
        cyc++;
        if (cyc > 4000)
        begin
            err_total++;
            summarize();
        end
    end

    // Main sequence with a second reset in mid-run
    initial
    begin
        void'($urandom(32'hbaf9));
        {rst_b, adp, dep, oc, cold, hs, hr, chg, learn} = 9'h000;
        {hold, sh, ctrl_rest} = 20'h0;
        temp = 16'd125;
        bat_mv = 16'd12000;
        sys_mv = 16'd12000;
        err_total = 0;
        checked = 0;
        cyc = 0;
        repeat (3) step(1'b0);
        repeat (1500) step(1'b1);
        repeat (3) step(1'b0);
        repeat (1500) step(1'b1);
        repeat (2) @(posedge clk);
        summarize();
    end
endmodule
